//--- verilog/tfc_params.svh
`ifndef TFC_PARAMS_SVH
`define TFC_PARAMS_SVH
// What this block does
// - silently discard vendor type 1 messages to bridge
// - interrupt, power, error, unlock, power-limit messages need class 0
// - toward-root routing legal only on downstream ports
// - broadcast routing legal only on upstream ports
// - gathered routing: downstream only, acknowledge message only
// - legacy interrupt messages legal only downstream
// - ingress class must map to channel 0
// - egress class must map to channel 0
// - access checks only in downstream switch mode
// - redirect is normal, nothing logged
// - block is access violation, logged
// - no source validation on local/gathered messages
// - non-posted violation gets abort completion, not counted
// - any violation sets signaled target abort flag
// - nonfatal and non-posted means advisory, else uncorrectable
// - violation captures header then drops packet
// - direct translated peer packets use egress/redirect checks
// - malformed: uncorrectable, header logged, nullified
// - only highest priority error reported: malformed over access

// routing field codes of the received packet
`define TFC_RT_ADDR 3'h0
`define TFC_RT_ID 3'h1
`define TFC_RT_TO_ROOT 3'h2
`define TFC_RT_BCAST 3'h3
`define TFC_RT_LOCAL 3'h4
`define TFC_RT_GATHER 3'h5
// message class codes
`define TFC_MSG_NONE 4'h0
`define TFC_MSG_INTX 4'h1
`define TFC_MSG_PM 4'h2
`define TFC_MSG_ERR 4'h3
`define TFC_MSG_UNLOCK 4'h4
`define TFC_MSG_PWRLIM 4'h5
`define TFC_MSG_PME_ACK 4'h6
`define TFC_MSG_VEND0 4'h7
`define TFC_MSG_VEND1 4'h8
`define TFC_MSG_OTHER 4'h9
// traffic class that restricted messages must use
`define TFC_TC_ZERO 3'h0
// header width captured into the log
`define TFC_HDR_W 128
`endif

//--- verilog/tfc_pkg.sv
package tfc_pkg;
    typedef logic [2:0] tfc_tc_t;
    typedef logic [7:0] tfc_map_t;
    typedef logic [127:0] tfc_hdr_t;
    // registered state of the checker
    typedef struct packed {
        logic rx_mal;
        logic rx_acs;
        logic rx_drop;
        logic rx_null;
        logic rx_disc;
        logic rx_adv;
        logic rx_uncor;
        logic rx_cpl_ca;
        logic sta_set;
        logic hdr_vld;
        tfc_hdr_t hdr;
        logic tx_mal;
        logic tx_null;
    } tfc_state_s;
endpackage

//--- verilog/tfc_checker.sv
`include "tfc_params.svh"
module tfc_checker (
    input wire logic CLK, // 200 MHz core clock
    input wire logic RST, // synchronous reset, high
    input wire logic DSP_MODE, // port is a downstream switch port
    input wire tfc_pkg::tfc_map_t RX_MAP, // ingress class-to-channel map
    input wire tfc_pkg::tfc_map_t TX_MAP, // egress class-to-channel map
    input wire logic ACS_SEV_FATAL, // access violation severity is fatal
    input wire logic RX_VALID, // received packet header present
    input wire logic [2:0] RX_ROUTE, // routing code
    input wire logic [3:0] RX_MSG, // message class code
    input wire tfc_pkg::tfc_tc_t RX_TC, // traffic class
    input wire logic RX_NONPOSTED, // packet is a non-posted request
    input wire logic RX_TO_BRIDGE, // packet targets the bridge function
    input wire logic RX_ACS_SV_FAIL, // source validation found a bad source
    input wire logic RX_ACS_TB_FAIL, // translation blocking fires
    input wire logic RX_ACS_P2P_BLOCK, // peer egress control blocks
    input wire logic RX_ACS_REDIRECT, // peer redirect chosen
    input wire tfc_pkg::tfc_hdr_t RX_HDR, // packet header
    input wire logic TX_VALID, // packet about to transmit
    input wire tfc_pkg::tfc_tc_t TX_TC, // its traffic class
    output logic RX_MALFORMED, // malformed violation pulse
    output logic RX_ACS_VIOL, // access violation pulse
    output logic RX_DROP, // drop the received packet
    output logic RX_NULLIFY, // nullify the received packet
    output logic RX_DISCARD, // silent discard, no error
    output logic RX_ADVISORY, // advisory correctable processing
    output logic RX_UNCORR, // uncorrectable processing
    output logic RX_CPL_ABORT, // send completer-abort completion
    output logic STA_SET, // set signaled_target_abort_flag
    output logic HDR_LOG_VALID, // header log write strobe
    output tfc_pkg::tfc_hdr_t HDR_LOG, // header to log
    output logic TX_MALFORMED, // egress malformed pulse
    output logic TX_NULLIFY // nullify egress packet
);
    import tfc_pkg::*;

    tfc_state_s st; // registered state
    tfc_state_s next_st; // next state

    // class-to-channel check, used for both directions
    function automatic logic tc_on_vc0(input tfc_map_t map, input tfc_tc_t tc);
        return map[tc];
    endfunction

    // messages that must carry class zero
    function automatic logic tc0_only(input logic [3:0] msg);
        return (msg == `TFC_MSG_INTX) || (msg == `TFC_MSG_PM) ||
            (msg == `TFC_MSG_ERR) || (msg == `TFC_MSG_UNLOCK) ||
            (msg == `TFC_MSG_PWRLIM);
    endfunction

    logic up_port; // upstream port when not downstream mode
    logic mal_tc0; // restricted message with nonzero class
    logic mal_route; // routing direction illegal
    logic mal_vc; // class not mapped to channel 0
    logic malformed; // any ingress malformation
    logic vend1_disc; // vendor type 1 to bridge
    logic sv_skip; // source validation not applied
    logic acs_block; // any blocking access check
    logic acs_viol; // reported access violation

    // ingress classification
    always_comb begin
        up_port = !DSP_MODE;
        mal_tc0 = tc0_only(RX_MSG) && (RX_TC != `TFC_TC_ZERO);
        mal_route = 1'b0;
        if ((RX_ROUTE == `TFC_RT_TO_ROOT) && up_port) begin
            mal_route = 1'b1;
        end
        if ((RX_ROUTE == `TFC_RT_BCAST) && !up_port) begin
            mal_route = 1'b1;
        end
        if ((RX_ROUTE == `TFC_RT_GATHER) && (up_port || (RX_MSG != `TFC_MSG_PME_ACK))) begin
            mal_route = 1'b1;
        end
        if ((RX_MSG == `TFC_MSG_INTX) && up_port) begin
            mal_route = 1'b1;
        end
        mal_vc = !tc_on_vc0(RX_MAP, RX_TC);
        malformed = mal_tc0 || mal_route || mal_vc;
        // vendor type 1 messages to the bridge vanish quietly
        vend1_disc = (RX_MSG == `TFC_MSG_VEND1) && RX_TO_BRIDGE && !malformed;
        // local and gathered messages skip source validation
        sv_skip = (RX_ROUTE == `TFC_RT_LOCAL) || (RX_ROUTE == `TFC_RT_GATHER);
        // direct translated peer packets arrive here via peer egress block input
        acs_block = (RX_ACS_SV_FAIL && !sv_skip) || RX_ACS_TB_FAIL ||
            RX_ACS_P2P_BLOCK;
        // only downstream mode runs access checks; malformation outranks
        // a quietly discarded vendor message must raise no error at all,
        // so it also hides any access violation on the same packet
        acs_viol = DSP_MODE && acs_block && !malformed && !vend1_disc;
    end

    // next-state fill
    always_comb begin
        next_st = st;
        next_st.rx_mal = RX_VALID && malformed;
        next_st.rx_acs = RX_VALID && acs_viol;
        // redirect alone raises nothing
        next_st.rx_drop = RX_VALID && (acs_viol || vend1_disc);
        next_st.rx_null = RX_VALID && malformed;
        next_st.rx_disc = RX_VALID && vend1_disc;
        // advisory only for nonfatal non-posted violations
        next_st.rx_adv = RX_VALID && acs_viol && !ACS_SEV_FATAL && RX_NONPOSTED;
        next_st.rx_uncor = RX_VALID && (malformed ||
            (acs_viol && (ACS_SEV_FATAL || !RX_NONPOSTED)));
        next_st.rx_cpl_ca = RX_VALID && acs_viol && RX_NONPOSTED;
        next_st.sta_set = RX_VALID && acs_viol;
        next_st.hdr_vld = RX_VALID && (malformed || acs_viol);
        if (RX_VALID && (malformed || acs_viol)) begin
            next_st.hdr = RX_HDR; // capture
        end
        // egress mapping check
        next_st.tx_mal = TX_VALID && !tc_on_vc0(TX_MAP, TX_TC);
        next_st.tx_null = TX_VALID && !tc_on_vc0(TX_MAP, TX_TC);
    end

    // state register
    always_ff @(posedge CLK) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flops, pulses aligned with decisions
    assign RX_MALFORMED = st.rx_mal;
    assign RX_ACS_VIOL = st.rx_acs;
    assign RX_DROP = st.rx_drop;
    assign RX_NULLIFY = st.rx_null;
    assign RX_DISCARD = st.rx_disc;
    assign RX_ADVISORY = st.rx_adv;
    assign RX_UNCORR = st.rx_uncor;
    assign RX_CPL_ABORT = st.rx_cpl_ca;
    assign STA_SET = st.sta_set;
    assign HDR_LOG_VALID = st.hdr_vld;
    assign HDR_LOG = st.hdr;
    assign TX_MALFORMED = st.tx_mal;
    assign TX_NULLIFY = st.tx_null;

    // checks
    up_root_a: assert property (@(posedge CLK) disable iff (RST)
        RX_VALID && !DSP_MODE && RX_ROUTE == `TFC_RT_TO_ROOT |=> RX_MALFORMED)
        else $error("toward-root on upstream not malformed");
    bcast_dn_a: assert property (@(posedge CLK) disable iff (RST)
        RX_VALID && DSP_MODE && RX_ROUTE == `TFC_RT_BCAST |=> RX_MALFORMED && RX_NULLIFY)
        else $error("broadcast on downstream not malformed");
    gather_ack_a: assert property (@(posedge CLK) disable iff (RST)
        RX_VALID && RX_ROUTE == `TFC_RT_GATHER && RX_MSG != `TFC_MSG_PME_ACK |=> RX_MALFORMED)
        else $error("gathered non-ack not malformed");
    vc_map_a: assert property (@(posedge CLK) disable iff (RST)
        RX_VALID && !RX_MAP[RX_TC] |=> RX_MALFORMED)
        else $error("unmapped ingress class accepted");
    tx_map_a: assert property (@(posedge CLK) disable iff (RST)
        TX_VALID && !TX_MAP[TX_TC] |=> TX_MALFORMED && TX_NULLIFY)
        else $error("unmapped egress class accepted");
    acs_mode_a: assert property (@(posedge CLK) disable iff (RST)
        RX_ACS_VIOL |-> $past(DSP_MODE))
        else $error("access violation outside downstream mode");
    redirect_a: assert property (@(posedge CLK) disable iff (RST)
        RX_VALID && RX_ACS_REDIRECT && !RX_ACS_SV_FAIL && !RX_ACS_TB_FAIL
        && !RX_ACS_P2P_BLOCK |=> !RX_ACS_VIOL)
        else $error("redirect logged as violation");
    sta_pair_a: assert property (@(posedge CLK) disable iff (RST)
        RX_ACS_VIOL |-> STA_SET && RX_DROP && HDR_LOG_VALID)
        else $error("violation without flag, drop or log");
    advisory_a: assert property (@(posedge CLK) disable iff (RST)
        RX_ADVISORY |-> !RX_UNCORR && RX_CPL_ABORT)
        else $error("advisory mixed with uncorrectable");
    prio_a: assert property (@(posedge CLK) disable iff (RST)
        !(RX_MALFORMED && RX_ACS_VIOL))
        else $error("both errors reported");
    hdr_a: assert property (@(posedge CLK) disable iff (RST)
        RX_VALID && (DSP_MODE && RX_ACS_TB_FAIL) |=> HDR_LOG_VALID && HDR_LOG == $past(RX_HDR))
        else $error("header not captured");
    vend1_a: assert property (@(posedge CLK) disable iff (RST)
        RX_DISCARD |-> !RX_MALFORMED && !RX_ACS_VIOL && !RX_CPL_ABORT)
        else $error("discard raised an error");


    // restricted message classes must be zero whatever the map says
    tc0_msg_a: assert property (@(posedge CLK) disable iff (RST)
        RX_VALID && tc0_only(RX_MSG) && (RX_TC != `TFC_TC_ZERO)
        |=> RX_MALFORMED)
        else $error("restricted message with nonzero class accepted");

    // legacy interrupt arriving from above is illegal
    intx_up_a: assert property (@(posedge CLK) disable iff (RST)
        RX_VALID && !DSP_MODE && (RX_MSG == `TFC_MSG_INTX)
        |=> RX_MALFORMED)
        else $error("interrupt message on upstream not malformed");

    // gathered routing never legal on the upstream side
    gather_up_a: assert property (@(posedge CLK) disable iff (RST)
        RX_VALID && !DSP_MODE && (RX_ROUTE == `TFC_RT_GATHER)
        |=> RX_MALFORMED)
        else $error("gathered routing on upstream not malformed");

    // vendor type 1 to the bridge goes away without a trace
    vend1_drop_a: assert property (@(posedge CLK) disable iff (RST)
        RX_VALID && (RX_MSG == `TFC_MSG_VEND1) && RX_TO_BRIDGE && !malformed
        |=> RX_DISCARD && RX_DROP)
        else $error("vendor type 1 message not discarded");

    // a discard must not leave anything in the error log
    disc_quiet_a: assert property (@(posedge CLK) disable iff (RST)
        RX_DISCARD
        |-> !RX_UNCORR && !HDR_LOG_VALID && !STA_SET && !RX_ADVISORY)
        else $error("discard produced error processing");

    // malformed packets are nullified, never merely dropped
    null_a: assert property (@(posedge CLK) disable iff (RST)
        RX_MALFORMED
        |-> RX_NULLIFY && RX_UNCORR && HDR_LOG_VALID && !RX_DROP)
        else $error("malformed packet handled wrongly");

    // a peer egress block in downstream mode is a violation
    acs_log_a: assert property (@(posedge CLK) disable iff (RST)
        RX_VALID && DSP_MODE && RX_ACS_P2P_BLOCK && !malformed && !vend1_disc
        |=> RX_ACS_VIOL)
        else $error("blocked packet not logged as violation");

    // local routing ignores a failed source validation
    sv_skip_a: assert property (@(posedge CLK) disable iff (RST)
        RX_VALID && (RX_ROUTE == `TFC_RT_LOCAL) && !RX_ACS_TB_FAIL && !RX_ACS_P2P_BLOCK
        |=> !RX_ACS_VIOL)
        else $error("source validation applied to local message");

    // an abort completion only follows a violation
    cpl_ca_a: assert property (@(posedge CLK) disable iff (RST)
        RX_CPL_ABORT
        |-> RX_ACS_VIOL && !RX_MALFORMED)
        else $error("abort completion without violation");

    // blocked non-posted requests get their abort completion
    np_abort_a: assert property (@(posedge CLK) disable iff (RST)
        RX_VALID && DSP_MODE && RX_ACS_TB_FAIL && RX_NONPOSTED && !malformed && !vend1_disc
        |=> RX_CPL_ABORT && STA_SET)
        else $error("non-posted violation without abort completion");

    // the target abort flag is only set by a violation
    sta_only_a: assert property (@(posedge CLK) disable iff (RST)
        STA_SET
        |-> RX_ACS_VIOL)
        else $error("target abort flag without violation");

    // non-advisory violations take the uncorrectable path
    fatal_a: assert property (@(posedge CLK) disable iff (RST)
        RX_ACS_VIOL && !RX_ADVISORY
        |-> RX_UNCORR)
        else $error("non-advisory violation not uncorrectable");

    // nonfatal severity on a non-posted request is advisory
    adv_cause_a: assert property (@(posedge CLK) disable iff (RST)
        RX_VALID && DSP_MODE && RX_ACS_TB_FAIL && !ACS_SEV_FATAL && RX_NONPOSTED
        && !malformed && !vend1_disc
        |=> RX_ADVISORY)
        else $error("nonfatal non-posted violation not advisory");

    // drop and nullify are never both chosen
    drop_null_a: assert property (@(posedge CLK) disable iff (RST)
        !(RX_DROP && RX_NULLIFY))
        else $error("packet both dropped and nullified");

    // the log keeps its header until the next capture
    hdr_hold_a: assert property (@(posedge CLK) disable iff (RST)
        $past(!RST) && !HDR_LOG_VALID
        |-> $stable(HDR_LOG))
        else $error("header log changed without capture");

    // peer egress blocks on non-posted requests act like the others
    p2p_viol_a: assert property (@(posedge CLK) disable iff (RST)
        RX_VALID && DSP_MODE && RX_ACS_P2P_BLOCK && RX_NONPOSTED && !malformed && !vend1_disc
        |=> RX_CPL_ABORT && STA_SET && RX_DROP)
        else $error("peer egress block not handled");

    // upstream ports never raise access violations
    up_no_acs_a: assert property (@(posedge CLK) disable iff (RST)
        RX_VALID && !DSP_MODE
        |=> !RX_ACS_VIOL && !STA_SET && !RX_CPL_ABORT)
        else $error("access violation on upstream port");

    // every malformed pulse follows a received strobe
    mal_pulse_a: assert property (@(posedge CLK) disable iff (RST)
        RX_MALFORMED
        |-> $past(RX_VALID))
        else $error("malformed pulse without packet");

    // every access pulse follows a received strobe
    acs_pulse_a: assert property (@(posedge CLK) disable iff (RST)
        RX_ACS_VIOL
        |-> $past(RX_VALID))
        else $error("violation pulse without packet");

    // egress pulse comes with its nullify decision
    tx_pulse_a: assert property (@(posedge CLK) disable iff (RST)
        TX_MALFORMED
        |-> $past(TX_VALID) && TX_NULLIFY)
        else $error("egress pulse without nullify");

    // main scenarios worth seeing at least once
    mal_c: cover property (@(posedge CLK) RX_MALFORMED);
    disc_c: cover property (@(posedge CLK) RX_DISCARD && RX_DROP);
    acs_adv_c: cover property (@(posedge CLK) RX_ACS_VIOL && RX_ADVISORY);
    acs_unc_c: cover property (@(posedge CLK) RX_ACS_VIOL && RX_UNCORR);
    tx_c: cover property (@(posedge CLK) TX_MALFORMED);
endmodule

//--- test/tfc_link_model.sv
// far-side packet source feeding the ingress header path
module tfc_link_model (
    output logic RX_VALID, // header strobe
    output logic [2:0] RX_ROUTE, // routing code
    output logic [3:0] RX_MSG, // message class code
    output tfc_pkg::tfc_tc_t RX_TC, // traffic class
    output logic RX_NONPOSTED, // non-posted request
    output logic RX_TO_BRIDGE, // targets the bridge
    output logic RX_ACS_SV_FAIL, // bad source
    output logic RX_ACS_TB_FAIL, // translation blocked
    output logic RX_ACS_P2P_BLOCK, // peer egress blocked
    output logic RX_ACS_REDIRECT, // peer redirect
    output tfc_pkg::tfc_hdr_t RX_HDR // packet header
);
    timeunit 1ns;
    timeprecision 100ps;
    import tfc_pkg::*;
    // quiet link at time zero
    initial begin
        {RX_VALID, RX_ROUTE, RX_MSG, RX_TC, RX_NONPOSTED, RX_TO_BRIDGE} = '0;
        {RX_ACS_SV_FAIL, RX_ACS_TB_FAIL, RX_ACS_P2P_BLOCK, RX_ACS_REDIRECT} = '0;
        RX_HDR = '0;
    end
    // one whole header per call, caller times it off the sampling edge
    task automatic send(input logic [15:0] p, input tfc_hdr_t h);
        // class passed as asked; restricted messages leave class 0 only on purpose
        {RX_ROUTE, RX_MSG, RX_TC, RX_NONPOSTED, RX_TO_BRIDGE} = p[15:4];
        {RX_ACS_SV_FAIL, RX_ACS_TB_FAIL, RX_ACS_P2P_BLOCK, RX_ACS_REDIRECT} = p[3:0];
        RX_HDR = h;
        RX_VALID = 1'b1;
    endtask
    // released routing, message, class, non-posted and header fields flip so a stale value cannot pass for a live one
    task automatic idle;
        {RX_ROUTE, RX_MSG, RX_TC, RX_NONPOSTED} = ~{RX_ROUTE, RX_MSG, RX_TC, RX_NONPOSTED};
        RX_HDR = ~RX_HDR;
        RX_VALID = 1'b0;
    endtask
endmodule

//--- test/test_tfc_checker.sv
module test_tfc_checker;
    timeunit 1ns;
    timeprecision 100ps;
    import tfc_pkg::*;
    // one table row: port config, packet fields, expected flag vector
    typedef struct packed {logic dsp; logic sev; tfc_map_t map; logic [15:0] pkt;
        logic [8:0] exp;} tfc_row_s;
    // flags: malformed acs drop nullify discard advisory uncorr abort sta
    localparam logic [8:0] M = 9'h124, AN = 9'h0cb, AP = 9'h0c5, AF = 9'h0c7;
    localparam logic [8:0] D = 9'h050, OK = 9'h000;
    localparam tfc_map_t F = 8'hff;
    logic CLK, RST, DSP_MODE, ACS_SEV_FATAL, TX_VALID, RX_VALID;
    tfc_map_t RX_MAP, TX_MAP;
    tfc_tc_t TX_TC, RX_TC;
    logic [2:0] RX_ROUTE;
    logic [3:0] RX_MSG;
    logic RX_NONPOSTED, RX_TO_BRIDGE, RX_ACS_SV_FAIL, RX_ACS_TB_FAIL, RX_ACS_P2P_BLOCK;
    logic RX_ACS_REDIRECT, RX_MALFORMED, RX_ACS_VIOL, RX_DROP, RX_NULLIFY, RX_DISCARD;
    logic RX_ADVISORY, RX_UNCORR, RX_CPL_ABORT, STA_SET, HDR_LOG_VALID, TX_MALFORMED, TX_NULLIFY;
    tfc_hdr_t RX_HDR, HDR_LOG;
    int n_mismatch, compares;
    tfc_row_s rows[$];
    wire logic [8:0] seen = {RX_MALFORMED, RX_ACS_VIOL, RX_DROP, RX_NULLIFY, RX_DISCARD,
        RX_ADVISORY, RX_UNCORR, RX_CPL_ABORT, STA_SET};
    tfc_checker u_tfc_checker (.CLK, .RST, .DSP_MODE, .RX_MAP, .TX_MAP, .ACS_SEV_FATAL,
        .RX_VALID, .RX_ROUTE, .RX_MSG, .RX_TC, .RX_NONPOSTED, .RX_TO_BRIDGE, .RX_ACS_SV_FAIL,
        .RX_ACS_TB_FAIL, .RX_ACS_P2P_BLOCK, .RX_ACS_REDIRECT, .RX_HDR, .TX_VALID, .TX_TC,
        .RX_MALFORMED, .RX_ACS_VIOL, .RX_DROP, .RX_NULLIFY, .RX_DISCARD, .RX_ADVISORY,
        .RX_UNCORR, .RX_CPL_ABORT, .STA_SET, .HDR_LOG_VALID, .HDR_LOG, .TX_MALFORMED,
        .TX_NULLIFY);
    tfc_link_model u_tfc_link_model (.RX_VALID, .RX_ROUTE, .RX_MSG, .RX_TC, .RX_NONPOSTED,
        .RX_TO_BRIDGE, .RX_ACS_SV_FAIL, .RX_ACS_TB_FAIL, .RX_ACS_P2P_BLOCK, .RX_ACS_REDIRECT,
        .RX_HDR);
    // flags f: nonposted, to bridge, bad source, blocked, peer blocked, redirect
    function automatic tfc_row_s mk(input logic d, input logic [2:0] rt, input logic [3:0] mg,
        input tfc_tc_t tc, input logic [5:0] f, input logic sv, input tfc_map_t mp,
        input logic [8:0] e);
        return '{d, sv, mp, {rt, mg, tc, f}, e};
    endfunction
    // single compare point, every mismatch counted
    task automatic check(input string nm, input logic [127:0] got, input logic [127:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // 200 MHz core clock
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    // bound well above the ~35 cycles the tests need
    initial begin
        #2000;
        n_mismatch++;
        print_verdict();
    end
    // main sequence: rows back to back, then hand-written edge cases
    initial begin
        {RST, DSP_MODE, ACS_SEV_FATAL, TX_VALID, TX_TC} = 7'h41;
        RX_MAP = F;
        TX_MAP = F;
        rows.push_back(mk(0, 2, 0, 0, 6'b000000, 0, F, M));
        rows.push_back(mk(1, 2, 0, 0, 6'b000000, 0, F, OK));
        rows.push_back(mk(1, 3, 0, 0, 6'b000000, 0, F, M));
        rows.push_back(mk(0, 3, 0, 0, 6'b000000, 0, F, OK));
        rows.push_back(mk(1, 5, 6, 0, 6'b000000, 0, F, OK));
        rows.push_back(mk(1, 5, 9, 0, 6'b000000, 0, F, M));
        rows.push_back(mk(0, 5, 6, 0, 6'b000000, 0, F, M));
        rows.push_back(mk(0, 4, 1, 0, 6'b000000, 0, F, M));
        rows.push_back(mk(1, 4, 1, 0, 6'b000000, 0, F, OK));
        for (int m = 1; m <= 5; m++) rows.push_back(mk(1, 4, 4'(m), 1, 6'b000000, 0, F, M));
        rows.push_back(mk(0, 0, 0, 3, 6'b000000, 0, F, OK));
        rows.push_back(mk(0, 0, 0, 3, 6'b000000, 0, 8'hf7, M));
        rows.push_back(mk(0, 4, 8, 0, 6'b010000, 0, F, D));
        rows.push_back(mk(0, 0, 0, 0, 6'b001000, 0, F, OK));
        rows.push_back(mk(1, 0, 0, 0, 6'b100100, 0, F, AN));
        rows.push_back(mk(1, 0, 0, 0, 6'b000010, 0, F, AP));
        rows.push_back(mk(1, 0, 0, 0, 6'b101000, 1, F, AF));
        rows.push_back(mk(1, 0, 0, 0, 6'b000001, 0, F, OK));
        rows.push_back(mk(1, 4, 1, 0, 6'b001000, 0, F, OK));
        rows.push_back(mk(1, 5, 6, 0, 6'b101000, 0, F, OK));
        rows.push_back(mk(1, 3, 0, 0, 6'b100100, 0, F, M));
        repeat (4) @(negedge CLK);
        check("reset flags", {seen, HDR_LOG_VALID, TX_MALFORMED}, 11'h000);
        RST = 1'b0;
        // check the previous row while launching the next one
        for (int i = 0; i <= rows.size(); i++) begin
            @(negedge CLK);
            if (i > 0) begin
                check("rx flags", seen, rows[i-1].exp);
                check("log strobe", HDR_LOG_VALID, |rows[i-1].exp[8:7]);
                if (|rows[i-1].exp[8:7]) check("log header", HDR_LOG, {32{4'(i-1)}});
                $display("row %0d done", i - 1);
            end
            if (i < rows.size()) begin
                {DSP_MODE, ACS_SEV_FATAL, RX_MAP} = {rows[i].dsp, rows[i].sev, rows[i].map};
                u_tfc_link_model.send(rows[i].pkt, {32{4'(i)}});
            end else u_tfc_link_model.idle();
        end
        @(negedge CLK);
        check("pulses drop", {seen, HDR_LOG_VALID, TX_MALFORMED}, 11'h000);
        // egress check alongside an ingress malformation
        DSP_MODE = 1'b1;
        {TX_VALID, TX_TC, TX_MAP} = {1'b1, 3'h2, 8'hfb};
        u_tfc_link_model.send(rows[2].pkt, '1);
        @(negedge CLK);
        check("tx flags", {TX_MALFORMED, TX_NULLIFY}, 2'b11);
        check("rx flags", seen, M);
        TX_MAP = F;
        u_tfc_link_model.idle();
        @(negedge CLK);
        check("tx flags", {TX_MALFORMED, TX_NULLIFY}, 2'b00);
        check("log held", HDR_LOG, '1);
        TX_VALID = 1'b0;
        $display("egress test done");
        // reset in mid-run swallows a strobe
        DSP_MODE = 1'b0;
        RST = 1'b1;
        u_tfc_link_model.send(rows[0].pkt, '0);
        @(negedge CLK);
        check("reset flags", {seen, HDR_LOG_VALID}, 10'h000);
        check("reset log", HDR_LOG, '0);
        RST = 1'b0;
        u_tfc_link_model.idle();
        @(negedge CLK);
        check("after reset", {seen, HDR_LOG_VALID}, 10'h000);
        $display("reset test done");
        print_verdict();
    end
endmodule
